// file: verilog/lpfh_frame_handler.sv
// Purpose: decode parameter request frames, apply values, emit replies
// Assumes: rx and tx streams synchronous to clk, valid/ready handshake
// Notes: replies pass through a small fifo so the host may stall them

// byte fifo with honest full and empty
module lpfh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // fill side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // drain side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // handshakes are combinational from the fill count
    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // storage is not reset, only pointers and count are
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module lpfh_frame_handler #(
    parameter int FIFO_DEPTH = lpfh_pkg::TX_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // request byte stream
    input wire logic [7:0] rxByte,
    input wire logic rxValid,
    output logic rxReady,
    // response byte stream
    output logic [7:0] txByte,
    output logic txValid,
    input wire logic txReady,
    // parameters in force, temperature input and drop pulse
    input wire logic [15:0] moduleTemp,
    output logic [15:0] nodeLabel,
    output logic [15:0] serialRate,
    output logic [15:0] framingMode,
    output logic frameDropped
);
    lpfh_pkg::lpfh_state_t state_r;
    logic [15:0] lenField_r;
    logic [15:0] bodyIdx_r;
    logic [7:0] sum_r;
    logic [7:0] frameType_r;
    logic [7:0] frameId_r;
    logic [15:0] cmd_r;
    logic [15:0] valBuf_r;
    logic [7:0] status_r;
    logic hasData_r;
    logic [15:0] readVal_r;
    logic [3:0] respIdx_r;
    logic dropped_r;
    logic [15:0] paramAct_r [lpfh_pkg::NUM_PARAMS];
    logic [15:0] paramPend_r [lpfh_pkg::NUM_PARAMS];
    logic [lpfh_pkg::NUM_PARAMS-1:0] pendValid_r;
    logic take;
    logic csumOk;
    logic isWrite;
    logic [7:0] statusNxt;
    logic [1:0] slot;
    logic applyPend;
    logic doWrite;
    logic [7:0] pushByte;
    logic pushValid;
    logic pushReady;
    logic [3:0] respLast;

    // parameter slot of a command, none for read-only or unknown ones
    function automatic logic [1:0] slotOf(input logic [15:0] c);
        unique case (c)
            lpfh_pkg::CMD_NODE: slotOf = lpfh_pkg::IDX_NODE;
            lpfh_pkg::CMD_RATE: slotOf = lpfh_pkg::IDX_RATE;
            lpfh_pkg::CMD_FRAMING: slotOf = lpfh_pkg::IDX_FRAMING;
            default: slotOf = lpfh_pkg::IDX_NONE;
        endcase
    endfunction

    // input is held off while a request is executed or answered
    assign rxReady = (state_r != lpfh_pkg::ST_EXEC) && (state_r != lpfh_pkg::ST_RESP);
    assign take = rxValid && rxReady;
    assign csumOk = (8'(sum_r + rxByte) == lpfh_pkg::CSUM_GOOD);
    assign isWrite = (lenField_r > lpfh_pkg::MIN_BODY);
    assign slot = slotOf(cmd_r);

    // request decoding: share one path for both types
    always_comb begin
        if (slot == lpfh_pkg::IDX_NONE && cmd_r != lpfh_pkg::CMD_TEMP
                && cmd_r != lpfh_pkg::CMD_APPLY) begin
            statusNxt = lpfh_pkg::ST_BAD_CMD;
        end else if (isWrite && cmd_r == lpfh_pkg::CMD_TEMP) begin
            statusNxt = lpfh_pkg::ST_ERROR; // temperature is read-only
        end else if (isWrite && (cmd_r == lpfh_pkg::CMD_APPLY
                || lenField_r - lpfh_pkg::MIN_BODY > lpfh_pkg::MAX_VALUE)) begin
            statusNxt = lpfh_pkg::ST_BAD_PARAM;
        end else begin
            statusNxt = lpfh_pkg::ST_OK;
        end
    end

    // pending values land on any good immediate frame or the apply command
    assign applyPend = (state_r == lpfh_pkg::ST_EXEC) && statusNxt == lpfh_pkg::ST_OK
        && (frameType_r == lpfh_pkg::TYPE_IMM || cmd_r == lpfh_pkg::CMD_APPLY);
    assign doWrite = (state_r == lpfh_pkg::ST_EXEC) && statusNxt == lpfh_pkg::ST_OK
        && isWrite && slot != lpfh_pkg::IDX_NONE;

    // frame receive sequencer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= lpfh_pkg::ST_IDLE;
        end else begin
            unique case (state_r)
                lpfh_pkg::ST_IDLE: begin
                    if (take && rxByte == lpfh_pkg::START_BYTE) begin
                        state_r <= lpfh_pkg::ST_LENH;
                    end
                end
                lpfh_pkg::ST_LENH: begin
                    if (take) begin
                        state_r <= lpfh_pkg::ST_LENL;
                    end
                end
                lpfh_pkg::ST_LENL: begin
                    if (take) begin
                        state_r <= ({lenField_r[15:8], rxByte} == '0) ?
                            lpfh_pkg::ST_CSUM : lpfh_pkg::ST_BODY;
                    end
                end
                lpfh_pkg::ST_BODY: begin
                    if (take && bodyIdx_r + 16'h0001 == lenField_r) begin
                        state_r <= lpfh_pkg::ST_CSUM;
                    end
                end
                lpfh_pkg::ST_CSUM: begin
                    if (take) begin
                        // short body, foreign type or bad sum goes nowhere
                        if (csumOk && lenField_r >= lpfh_pkg::MIN_BODY
                                && (frameType_r == lpfh_pkg::TYPE_IMM
                                || frameType_r == lpfh_pkg::TYPE_QUEUE)) begin
                            state_r <= lpfh_pkg::ST_EXEC;
                        end else begin
                            state_r <= lpfh_pkg::ST_IDLE;
                        end
                    end
                end
                lpfh_pkg::ST_EXEC: begin
                    state_r <= (frameId_r == '0) ?
                        lpfh_pkg::ST_IDLE : lpfh_pkg::ST_RESP;
                end
                lpfh_pkg::ST_RESP: begin
                    if (pushReady && respIdx_r == respLast) begin
                        state_r <= lpfh_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // field capture and running sum over the body
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lenField_r <= '0;
            bodyIdx_r <= '0;
            sum_r <= '0;
            frameType_r <= '0;
            frameId_r <= '0;
            cmd_r <= '0;
            valBuf_r <= '0;
        end else if (take) begin
            if (state_r == lpfh_pkg::ST_LENH) begin
                lenField_r[15:8] <= rxByte;
            end
            if (state_r == lpfh_pkg::ST_LENL) begin
                lenField_r[7:0] <= rxByte;
                bodyIdx_r <= '0;
                sum_r <= '0;
                frameType_r <= '0;
                valBuf_r <= '0;
            end
            if (state_r == lpfh_pkg::ST_BODY) begin
                bodyIdx_r <= bodyIdx_r + 16'h0001;
                sum_r <= 8'(sum_r + rxByte);
                unique case (bodyIdx_r)
                    lpfh_pkg::POS_TYPE: frameType_r <= rxByte;
                    lpfh_pkg::POS_ID: frameId_r <= rxByte;
                    lpfh_pkg::POS_CMD_HI: cmd_r[15:8] <= rxByte;
                    lpfh_pkg::POS_CMD_LO: cmd_r[7:0] <= rxByte;
                    default: valBuf_r <= {valBuf_r[7:0], rxByte};
                endcase
            end
        end
    end

    // active and pending values; a direct write beats the pending copy
    always_ff @(posedge clk) begin
        if (!rstn) begin
            paramAct_r[lpfh_pkg::IDX_NODE] <= lpfh_pkg::RST_NODE;
            paramAct_r[lpfh_pkg::IDX_RATE] <= lpfh_pkg::RST_RATE;
            paramAct_r[lpfh_pkg::IDX_FRAMING] <= lpfh_pkg::RST_FRAMING;
            for (int i = 0; i < lpfh_pkg::NUM_PARAMS; i++) begin
                paramPend_r[i] <= '0;
            end
            pendValid_r <= '0;
        end else begin
            if (applyPend) begin
                for (int i = 0; i < lpfh_pkg::NUM_PARAMS; i++) begin
                    if (pendValid_r[i]) begin
                        paramAct_r[i] <= paramPend_r[i];
                    end
                end
                pendValid_r <= '0;
            end
            if (doWrite && frameType_r == lpfh_pkg::TYPE_IMM) begin
                paramAct_r[slot] <= valBuf_r;
            end
            if (doWrite && frameType_r == lpfh_pkg::TYPE_QUEUE) begin
                paramPend_r[slot] <= valBuf_r;
                pendValid_r[slot] <= 1'b1;
            end
        end
    end

    // reply contents are fixed in the execute cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            status_r <= lpfh_pkg::ST_OK;
            hasData_r <= 1'b0;
            readVal_r <= '0;
        end else if (state_r == lpfh_pkg::ST_EXEC) begin
            status_r <= statusNxt;
            // the apply command has no setting of its own, so its reply carries no value
            hasData_r <= !isWrite && statusNxt == lpfh_pkg::ST_OK
                && cmd_r != lpfh_pkg::CMD_APPLY;
            // reads report what is in force, never a pending value
            readVal_r <= (cmd_r == lpfh_pkg::CMD_TEMP) ? moduleTemp
                : (slot == lpfh_pkg::IDX_NONE) ? 16'h0000 : paramAct_r[slot];
        end
    end

    // reply byte sequencer, stalled by the fifo
    always_ff @(posedge clk) begin
        if (!rstn) begin
            respIdx_r <= '0;
        end else if (state_r != lpfh_pkg::ST_RESP) begin
            respIdx_r <= '0;
        end else if (pushReady) begin
            respIdx_r <= respIdx_r + 4'h1;
        end
    end

    // one-cycle pulse for a frame thrown away at its checksum byte
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dropped_r <= 1'b0;
        end else begin
            dropped_r <= take && state_r == lpfh_pkg::ST_CSUM && !(csumOk
                && lenField_r >= lpfh_pkg::MIN_BODY
                && (frameType_r == lpfh_pkg::TYPE_IMM
                || frameType_r == lpfh_pkg::TYPE_QUEUE));
        end
    end

    // reply layout: start, length, type, id, command, status, value, sum
    always_comb begin
        logic [15:0] rlen;
        logic [7:0] rsum;
        rlen = hasData_r ? lpfh_pkg::RESP_DATA_BODY : lpfh_pkg::RESP_BODY;
        rsum = 8'(lpfh_pkg::TYPE_RESP + frameId_r + cmd_r[15:8] + cmd_r[7:0] + status_r);
        if (hasData_r) begin
            rsum = 8'(rsum + readVal_r[15:8] + readVal_r[7:0]);
        end
        respLast = 4'(rlen + 16'h0003);
        unique case (respIdx_r)
            4'h0: pushByte = lpfh_pkg::START_BYTE;
            4'h1: pushByte = rlen[15:8];
            4'h2: pushByte = rlen[7:0];
            4'h3: pushByte = lpfh_pkg::TYPE_RESP;
            4'h4: pushByte = frameId_r;
            4'h5: pushByte = cmd_r[15:8];
            4'h6: pushByte = cmd_r[7:0];
            4'h7: pushByte = status_r;
            default: pushByte = (respIdx_r == respLast) ?
                8'(lpfh_pkg::CSUM_GOOD - rsum) : (respIdx_r == 4'h8) ?
                readVal_r[15:8] : readVal_r[7:0];
        endcase
    end
    assign pushValid = (state_r == lpfh_pkg::ST_RESP);

    // replies drain at the host's pace
    lpfh_fifo #(
        .WIDTH(lpfh_pkg::BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_txFifo (
        .clk(clk),
        .rstn(rstn),
        .inData(pushByte),
        .inValid(pushValid),
        .inReady(pushReady),
        .outData(txByte),
        .outValid(txValid),
        .outReady(txReady)
    );

    assign nodeLabel = paramAct_r[lpfh_pkg::IDX_NODE];
    assign serialRate = paramAct_r[lpfh_pkg::IDX_RATE];
    assign framingMode = paramAct_r[lpfh_pkg::IDX_FRAMING];
    assign frameDropped = dropped_r;

    // checks
    sequence s_queued_rate;
        state_r == lpfh_pkg::ST_EXEC && doWrite && frameType_r == lpfh_pkg::TYPE_QUEUE
            && slot == lpfh_pkg::IDX_RATE && !applyPend;
    endsequence
    sequence s_bad_sum;
        take && state_r == lpfh_pkg::ST_CSUM && !csumOk;
    endsequence

    a_start_gate: assert property (@(posedge clk) disable iff (!rstn)
        state_r == lpfh_pkg::ST_IDLE && take && rxByte != lpfh_pkg::START_BYTE
        |=> state_r == lpfh_pkg::ST_IDLE) else $error("idle left without start byte");
    a_len_high: assert property (@(posedge clk) disable iff (!rstn)
        state_r == lpfh_pkg::ST_LENH && take ##1 take
        |=> lenField_r == {$past(rxByte, 2), $past(rxByte)}) else $error("length misassembled");
    a_zero_id_quiet: assert property (@(posedge clk) disable iff (!rstn)
        state_r == lpfh_pkg::ST_EXEC && frameId_r == '0
        |=> state_r == lpfh_pkg::ST_IDLE ##1 !pushValid) else $error("reply for id zero");
    a_bad_sum_drop: assert property (@(posedge clk) disable iff (!rstn)
        s_bad_sum |=> frameDropped && state_r == lpfh_pkg::ST_IDLE
        && $stable(serialRate)) else $error("bad checksum not dropped");
    a_imm_write: assert property (@(posedge clk) disable iff (!rstn)
        doWrite && frameType_r == lpfh_pkg::TYPE_IMM && slot == lpfh_pkg::IDX_RATE
        |=> serialRate == $past(valBuf_r)) else $error("immediate write not applied");
    a_queue_hold: assert property (@(posedge clk) disable iff (!rstn)
        s_queued_rate |=> $stable(serialRate) && pendValid_r[lpfh_pkg::IDX_RATE])
        else $error("queued rate applied early");
    a_resp_type: assert property (@(posedge clk) disable iff (!rstn)
        pushValid && respIdx_r == 4'h3 |-> pushByte == lpfh_pkg::TYPE_RESP
        && pushByte != frameType_r) else $error("reply type wrong");
    a_resp_id: assert property (@(posedge clk) disable iff (!rstn)
        state_r == lpfh_pkg::ST_EXEC && frameId_r != '0
        |-> ##[1:40] (pushValid && respIdx_r == 4'h4 && pushByte == frameId_r))
        else $error("reply id not echoed");
    a_read_data: assert property (@(posedge clk) disable iff (!rstn)
        state_r == lpfh_pkg::ST_EXEC && !isWrite && statusNxt == lpfh_pkg::ST_OK
        && cmd_r != lpfh_pkg::CMD_APPLY
        |=> hasData_r && respLast == 4'hA) else $error("read reply lacks value");
endmodule

// file: verilog/lpfh_pkg.sv
// Purpose: constants for the local parameter frame handler
// Assumes: byte-wide request and response streams
// Notes: command codes are two ASCII characters, first one high
package lpfh_pkg;
    // framing
    localparam logic [7:0] START_BYTE = 8'h7E;
    localparam logic [7:0] TYPE_IMM = 8'h08;
    localparam logic [7:0] TYPE_QUEUE = 8'h09;
    localparam logic [7:0] TYPE_RESP = 8'h88;
    localparam logic [7:0] CSUM_GOOD = 8'hFF;
    localparam logic [15:0] MIN_BODY = 16'h0004;
    localparam logic [15:0] MAX_VALUE = 16'h0002;
    localparam logic [15:0] RESP_BODY = 16'h0005;
    localparam logic [15:0] RESP_DATA_BODY = 16'h0007;
    // body byte positions, counted from the type byte
    localparam logic [15:0] POS_TYPE = 16'h0000;
    localparam logic [15:0] POS_ID = 16'h0001;
    localparam logic [15:0] POS_CMD_HI = 16'h0002;
    localparam logic [15:0] POS_CMD_LO = 16'h0003;
    // parameter commands
    localparam logic [15:0] CMD_APPLY = 16'h4143;
    localparam logic [15:0] CMD_NODE = 16'h4E49;
    localparam logic [15:0] CMD_TEMP = 16'h5450;
    localparam logic [15:0] CMD_RATE = 16'h4244;
    localparam logic [15:0] CMD_FRAMING = 16'h4150;
    // writable parameter slots
    localparam int NUM_PARAMS = 3;
    localparam logic [1:0] IDX_NODE = 2'h0;
    localparam logic [1:0] IDX_RATE = 2'h1;
    localparam logic [1:0] IDX_FRAMING = 2'h2;
    localparam logic [1:0] IDX_NONE = 2'h3;
    localparam logic [15:0] RST_NODE = 16'h0000;
    localparam logic [15:0] RST_RATE = 16'h0003;
    localparam logic [15:0] RST_FRAMING = 16'h0000;
    // response status codes
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_ERROR = 8'h01;
    localparam logic [7:0] ST_BAD_CMD = 8'h02;
    localparam logic [7:0] ST_BAD_PARAM = 8'h03;
    // buffering
    localparam int TX_FIFO_DEPTH = 8;
    localparam int BYTE_W = 8;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_LENH = 7'h02,
        ST_LENL = 7'h04,
        ST_BODY = 7'h08,
        ST_CSUM = 7'h10,
        ST_EXEC = 7'h20,
        ST_RESP = 7'h40
    } lpfh_state_t;
endpackage

// file: sim/lpfh_host_model.sv
// Purpose: host side of the reply stream, taking reply bytes with random stalls
// Assumes: ready changes only at the falling edge of clk
// Notes: a stall request holds ready low so the reply fifo fills until it refuses
module lpfh_host_model (
    // clock
    input wire logic clk,
    // control from the bench
    input wire logic stall,
    // reply stream
    input wire logic txValid,
    output logic txReady
);
    timeunit 1ns;
    timeprecision 1ns;

    int seed = 18959;
    int taken = 0;

    // ready drops at random so replies see back pressure, not only the easy path
    always @(negedge clk) begin
        txReady <= !stall && ($random(seed) % 4 != 0);
    end

    // count bytes taken; the bench holds this against the bytes it noted
    always @(posedge clk) begin
        if (txValid === 1'b1 && txReady === 1'b1) begin
            taken++;
        end
    end
endmodule

// file: sim/lpfh_frame_handler_bench.sv
// Purpose: self-checking bench for the parameter frame handler
// Assumes: requests driven at the falling edge; host model drains the replies
// Notes: every expected reply byte is noted in a queue and checked as it leaves
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module lpfh_frame_handler_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rstn, rxValid, rxReady, txValid, txReady, frameDropped, stall;
    logic [7:0] rxByte, txByte, e, rid;
    logic [15:0] moduleTemp, nodeLabel, serialRate, framingMode, v;
    logic [7:0] expQ[$];
    int failures = 0;
    int num_checks = 0;
    int seed = 18959;
    int cycles = 0;
    int drops = 0;
    int noted = 0;
    int d0;

    // clock at 10 MHz
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    lpfh_frame_handler u_dut (.clk(clk), .rstn(rstn), .rxByte(rxByte), .rxValid(rxValid),
        .rxReady(rxReady), .txByte(txByte), .txValid(txValid), .txReady(txReady),
        .moduleTemp(moduleTemp), .nodeLabel(nodeLabel), .serialRate(serialRate),
        .framingMode(framingMode), .frameDropped(frameDropped));

    lpfh_host_model u_host (.clk(clk), .stall(stall), .txValid(txValid), .txReady(txReady));

    task automatic close_out();
        $display("Comparisons: %0d, mismatches: %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // note the reply a request should produce; id zero produces nothing
    task automatic expReply(input logic [7:0] id, input logic [15:0] cmd,
        input logic [7:0] st, input bit hasV, input logic [15:0] val);
        logic [7:0] b[$];
        logic [7:0] s;
        if (id == 8'h00) return;
        b = {lpfh_pkg::TYPE_RESP, id, cmd[15:8], cmd[7:0], st};
        if (hasV) b = {b, val[15:8], val[7:0]};
        s = 8'h00;
        foreach (b[i]) s += b[i];
        noted += b.size() + 4;
        expQ = {expQ, lpfh_pkg::START_BYTE, 8'h00, 8'(b.size()), b, 8'hFF - s};
    endtask

    // offer one byte and hold it until an edge with ready high takes it
    task automatic sendByte(input logic [7:0] b);
        int n;
        bit ok;
        n = 0;
        rxByte = b;
        rxValid = 1'b1;
        do begin
            ok = (rxReady === 1'b1);
            @(posedge clk);
            @(negedge clk);
            n++;
        end while (!ok && n < 500);
    endtask

    // mode 0 good, 1 corrupt checksum, 2 length one short of the minimum body
    task automatic sendFrame(input logic [7:0] typ, input logic [7:0] id,
        input logic [15:0] cmd, input int nv, input logic [15:0] val, input int mode);
        logic [7:0] b[$];
        logic [7:0] s;
        b = {typ, id, cmd[15:8], cmd[7:0]};
        if (nv == 2) b.push_back(val[15:8]);
        if (nv > 0) b.push_back(val[7:0]);
        if (mode == 2) void'(b.pop_back());
        s = 8'h00;
        foreach (b[i]) s += b[i];
        s = 8'hFF - s;
        if (mode == 1) s ^= 8'h01;
        b = {lpfh_pkg::START_BYTE, 8'h00, 8'(b.size()), b, s};
        foreach (b[i]) sendByte(b[i]);
        // a released line shows the inverse so a stale byte cannot pass
        rxValid = 1'b0;
        rxByte = ~rxByte;
        @(negedge clk);
    endtask

    // wait, bounded, for the noted reply bytes to leave
    task automatic settle();
        int n;
        n = 0;
        while (expQ.size() != 0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
        `CHK(expQ.size(), 0)
    endtask

    // reply watcher, drop counter and hang guard
    always @(posedge clk) begin
        cycles++;
        if (frameDropped === 1'b1) drops++;
        if (txValid === 1'b1 && txReady === 1'b1) begin
            if (expQ.size() == 0) begin
                `CHK(expQ.size(), 1)
            end else begin
                e = expQ.pop_front();
                `CHK(txByte, e)
            end
        end
        // hang guard last, so nothing in this process runs after the report
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        rstn = 1'b0;
        rxValid = 1'b0;
        rxByte = 8'h00;
        stall = 1'b0;
        moduleTemp = 16'h0000;
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        moduleTemp = 16'($random(seed));
        `CHK(serialRate, lpfh_pkg::RST_RATE)
        `CHK(txValid, 1'b0)
        // idle junk, then a read whose reply is stalled until the fifo refuses
        stall = 1'b1;
        sendByte(8'h55);
        expReply(8'h17, lpfh_pkg::CMD_RATE, lpfh_pkg::ST_OK, 1, lpfh_pkg::RST_RATE);
        sendFrame(lpfh_pkg::TYPE_IMM, 8'h17, lpfh_pkg::CMD_RATE, 0, 16'h0000, 0);
        repeat (30) @(negedge clk);
        `CHK(txValid, 1'b1)
        `CHK(rxReady, 1'b0)
        stall = 1'b0;
        settle();
        // queued rate write stays pending, queued read shows the old value
        expReply(8'h53, lpfh_pkg::CMD_RATE, lpfh_pkg::ST_OK, 0, 16'h0000);
        sendFrame(lpfh_pkg::TYPE_QUEUE, 8'h53, lpfh_pkg::CMD_RATE, 1, 16'h0007, 0);
        expReply(8'h31, lpfh_pkg::CMD_RATE, lpfh_pkg::ST_OK, 1, lpfh_pkg::RST_RATE);
        sendFrame(lpfh_pkg::TYPE_QUEUE, 8'h31, lpfh_pkg::CMD_RATE, 0, 16'h0000, 0);
        settle();
        `CHK(serialRate, lpfh_pkg::RST_RATE)
        // queued apply command puts the pending rate in force
        expReply(8'h21, lpfh_pkg::CMD_APPLY, lpfh_pkg::ST_OK, 0, 16'h0000);
        sendFrame(lpfh_pkg::TYPE_QUEUE, 8'h21, lpfh_pkg::CMD_APPLY, 0, 16'h0000, 0);
        settle();
        `CHK(serialRate, 16'h0007)
        // pending framing mode applied by a later immediate read
        expReply(8'h44, lpfh_pkg::CMD_FRAMING, lpfh_pkg::ST_OK, 0, 16'h0000);
        sendFrame(lpfh_pkg::TYPE_QUEUE, 8'h44, lpfh_pkg::CMD_FRAMING, 2, 16'h0001, 0);
        settle();
        `CHK(framingMode, lpfh_pkg::RST_FRAMING)
        expReply(8'h45, lpfh_pkg::CMD_NODE, lpfh_pkg::ST_OK, 1, lpfh_pkg::RST_NODE);
        sendFrame(lpfh_pkg::TYPE_IMM, 8'h45, lpfh_pkg::CMD_NODE, 0, 16'h0000, 0);
        settle();
        `CHK(framingMode, 16'h0001)
        // silent immediate write with id zero
        sendFrame(lpfh_pkg::TYPE_IMM, 8'h00, lpfh_pkg::CMD_NODE, 2, 16'hA55A, 0);
        settle();
        `CHK(nodeLabel, 16'hA55A)
        // failing and refused requests, then a temperature read
        expReply(8'h61, lpfh_pkg::CMD_TEMP, lpfh_pkg::ST_ERROR, 0, 16'h0000);
        sendFrame(lpfh_pkg::TYPE_IMM, 8'h61, lpfh_pkg::CMD_TEMP, 2, 16'h1234, 0);
        expReply(8'h62, 16'h5858, lpfh_pkg::ST_BAD_CMD, 0, 16'h0000);
        sendFrame(lpfh_pkg::TYPE_QUEUE, 8'h62, 16'h5858, 0, 16'h0000, 0);
        expReply(8'h63, lpfh_pkg::CMD_APPLY, lpfh_pkg::ST_BAD_PARAM, 0, 16'h0000);
        sendFrame(lpfh_pkg::TYPE_IMM, 8'h63, lpfh_pkg::CMD_APPLY, 1, 16'h0001, 0);
        expReply(8'h64, lpfh_pkg::CMD_TEMP, lpfh_pkg::ST_OK, 1, moduleTemp);
        sendFrame(lpfh_pkg::TYPE_IMM, 8'h64, lpfh_pkg::CMD_TEMP, 0, 16'h0000, 0);
        settle();
        // random immediate writes with random nonzero ids
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            rid = 8'(({$random(seed)} % 255) + 1);
            expReply(rid, lpfh_pkg::CMD_NODE, lpfh_pkg::ST_OK, 0, 16'h0000);
            sendFrame(lpfh_pkg::TYPE_IMM, rid, lpfh_pkg::CMD_NODE, 2, v, 0);
            settle();
            `CHK(nodeLabel, v)
        end
        // immediate rate write takes effect at once
        expReply(8'h66, lpfh_pkg::CMD_RATE, lpfh_pkg::ST_OK, 0, 16'h0000);
        sendFrame(lpfh_pkg::TYPE_IMM, 8'h66, lpfh_pkg::CMD_RATE, 2, 16'h0005, 0);
        settle();
        `CHK(serialRate, 16'h0005)
        // back to back bad frames are dropped with no reply and no change
        d0 = drops;
        sendFrame(lpfh_pkg::TYPE_IMM, 8'h70, lpfh_pkg::CMD_NODE, 2, 16'h1111, 1);
        sendFrame(lpfh_pkg::TYPE_IMM, 8'h71, lpfh_pkg::CMD_NODE, 0, 16'h0000, 2);
        sendFrame(8'h10, 8'h72, lpfh_pkg::CMD_NODE, 2, 16'h2222, 0);
        settle();
        `CHK(drops - d0, 3)
        `CHK(nodeLabel, v)
        `CHK(serialRate, 16'h0005)
        `CHK(u_host.taken, noted)
        close_out();
    end
endmodule
